// [core/cadr_defs.svh]
// Purpose: Constants for the current converter result read-out block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Offsets, field positions and reset values only
`ifndef CADR_DEFS_SVH
`define CADR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CADR_OFF_PIN_DISABLE   8'h7E
`define CADR_OFF_INST_LOW      8'hEB
`define CADR_OFF_INST_HIGH     8'hEC
`define CADR_OFF_ACC_B0        8'hED
`define CADR_OFF_ACC_B1        8'hEE
`define CADR_OFF_ACC_B2        8'hEF
`define CADR_OFF_ACC_B3        8'hF0
`define CADR_OFF_SYNC_STATUS   8'hE0
`define CADR_OFF_IRQ_STATUS    8'hE1
`define CADR_OFF_IRQ_CLEAR     8'hE2
`define CADR_OFF_IRQ_ENABLE    8'hE3

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CADR_BIT_INST          0
`define CADR_BIT_ACC           1
`define CADR_ACC_LOW_W         14
`define CADR_CONV_W            18
`define CADR_PIN_W             2
`define CADR_RST_BYTE          8'h00
`define CADR_RST_WORD16        16'h0000
`define CADR_RST_WORD32        32'h0000_0000

`endif

// [core/cadr_pkg.sv]
// Purpose: Types for the current converter result read-out block
// Assumes: Constants live in cadr_defs.svh
// Notes:   Types only
package cadr_pkg;
  typedef logic [7:0]  cadr_byte_t;  // Register port data
  typedef logic [15:0] cadr_inst_t;  // Instantaneous result
  typedef logic [31:0] cadr_acc_t;   // Accumulated result
endpackage

// [core/cadr_result_readout.sv]
// Purpose: Result registers with frozen multi-byte reads, pin input disable, interrupts
// Assumes: Converter strobes and port pins come from other domains and are synchronised
// Notes:   Read data stands in the cycle after the read strobe
`include "cadr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Instant result two's complement, high/low bytes
// - Load instant result on each completion when not frozen
// - Low byte read freezes until high read
// - Instant busy flag high during read
// - Accumulated result 32 bits, refreshed on completion
// - 18-bit value on top, sign-filled low bits
// - Lower accumulated byte read freezes until top
// - Accumulated busy flag high during read
// - Disable bit turns off pin input buffer
// - Disabled pin reads zero in port input
// - Reserved disable bits read zero
// - Instant completion sets flag, one clears
// - Accumulated completion sets flag, one clears
module cadr_result_readout (
  input  wire logic                 clock,        // 25 MHz system clock
  input  wire logic                 rst,          // Synchronous reset, active high
  input  wire logic [7:0]           addr,         // Register byte offset
  input  wire logic [7:0]           wdata,        // Write data
  input  wire logic                 wr,           // Write strobe
  input  wire logic                 rd,           // Read strobe
  output logic      [7:0]           rdata,        // Read data, cycle after rd
  input  wire logic                 inst_done,    // Instant conversion complete (async level)
  input  wire logic [15:0]          inst_value,   // Instant result, stable around done
  input  wire logic                 acc_done,     // Accumulated conversion complete (async level)
  input  wire logic [17:0]          acc_value,    // Signed 18-bit converter output
  input  wire logic [1:0]           pin_raw,      // Port pin levels
  output logic      [1:0]           pin_buf_off,  // Digital input buffer off per pin
  output logic      [1:0]           port_input,   // Port input register bits
  output logic                      irq           // Level interrupt
);

  // ----------------------------------------------------------------
  // Synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] done_s1_q, done_s2_q, done_s3_q; // Completion strobe sync chain
  logic [1:0] pin_s1_q, pin_s2_q;              // Pin sync chain
  logic       inst_ev, acc_ev;                 // One-cycle completion events

  // Two flops before use; third stage only for the edge
  always_ff @(posedge clock) begin
    if (rst) begin
      done_s1_q <= 2'h0;
      done_s2_q <= 2'h0;
      done_s3_q <= 2'h0;
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
    end else begin
      done_s1_q <= {acc_done, inst_done};
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
    end
  end

  assign inst_ev = done_s2_q[0] & ~done_s3_q[0];
  assign acc_ev  = done_s2_q[1] & ~done_s3_q[1];

  // Sign-fill converter output into the accumulated layout
  function automatic cadr_pkg::cadr_acc_t acc_fill(input logic [17:0] v);
    acc_fill = {v, {`CADR_ACC_LOW_W{v[`CADR_CONV_W-1]}}};
  endfunction

  // ----------------------------------------------------------------
  // Result registers and freeze state
  // ----------------------------------------------------------------
  cadr_pkg::cadr_inst_t inst_q, inst_d;        // Visible instant result
  cadr_pkg::cadr_inst_t inst_pend_q, inst_pend_d; // Newest result while frozen
  logic                 inst_pv_q, inst_pv_d;  // Pending instant valid
  logic                 inst_busy_q, inst_busy_d; // Instant frozen / busy
  cadr_pkg::cadr_acc_t  acc_q, acc_d;          // Visible accumulated result
  cadr_pkg::cadr_acc_t  acc_pend_q, acc_pend_d; // Newest accumulated while frozen
  logic                 acc_pv_q, acc_pv_d;    // Pending accumulated valid
  logic                 acc_busy_q, acc_busy_d; // Accumulated frozen / busy
  logic                 rd_inst_lo, rd_inst_hi, rd_acc_lo, rd_acc_hi;

  assign rd_inst_lo = rd && addr == `CADR_OFF_INST_LOW;
  assign rd_inst_hi = rd && addr == `CADR_OFF_INST_HIGH;
  assign rd_acc_lo  = rd && (addr == `CADR_OFF_ACC_B0 || addr == `CADR_OFF_ACC_B1 ||
                             addr == `CADR_OFF_ACC_B2);
  assign rd_acc_hi  = rd && addr == `CADR_OFF_ACC_B3;

  // Next values of result and freeze state
  always_comb begin
    inst_d      = inst_q;
    inst_pend_d = inst_pend_q;
    inst_pv_d   = inst_pv_q;
    inst_busy_d = inst_busy_q;
    acc_d       = acc_q;
    acc_pend_d  = acc_pend_q;
    acc_pv_d    = acc_pv_q;
    acc_busy_d  = acc_busy_q;
    // Instant path
    if (inst_busy_q) begin
      if (inst_ev) begin                       // Newer overwrites older pending
        inst_pend_d = inst_value;
        inst_pv_d   = 1'b1;
      end
      if (rd_inst_hi) begin                    // High byte read ends freeze
        inst_busy_d = 1'b0;
        if (inst_ev) begin
          inst_d = inst_value;
        end else if (inst_pv_q) begin
          inst_d = inst_pend_q;
        end
        inst_pv_d = 1'b0;
      end
    end else if (inst_ev) begin
      inst_d = inst_value;                     // Load on completion
    end
    if (!inst_busy_q && rd_inst_lo) begin
      inst_busy_d = 1'b1;                      // Low byte read freezes
    end
    // Accumulated path
    if (acc_busy_q) begin
      if (acc_ev) begin
        acc_pend_d = acc_fill(acc_value);
        acc_pv_d   = 1'b1;
      end
      if (rd_acc_hi) begin                     // Top byte read ends freeze
        acc_busy_d = 1'b0;
        if (acc_ev) begin
          acc_d = acc_fill(acc_value);
        end else if (acc_pv_q) begin
          acc_d = acc_pend_q;
        end
        acc_pv_d = 1'b0;
      end
    end else if (acc_ev) begin
      acc_d = acc_fill(acc_value);             // Refresh on completion
    end
    if (!acc_busy_q && rd_acc_lo) begin
      acc_busy_d = 1'b1;                       // Lower byte read freezes
    end
  end

  // Register the result state
  always_ff @(posedge clock) begin
    if (rst) begin
      inst_q      <= `CADR_RST_WORD16;
      inst_pend_q <= `CADR_RST_WORD16;
      inst_pv_q   <= 1'b0;
      inst_busy_q <= 1'b0;
      acc_q       <= `CADR_RST_WORD32;
      acc_pend_q  <= `CADR_RST_WORD32;
      acc_pv_q    <= 1'b0;
      acc_busy_q  <= 1'b0;
    end else begin
      inst_q      <= inst_d;
      inst_pend_q <= inst_pend_d;
      inst_pv_q   <= inst_pv_d;
      inst_busy_q <= inst_busy_d;
      acc_q       <= acc_d;
      acc_pend_q  <= acc_pend_d;
      acc_pv_q    <= acc_pv_d;
      acc_busy_q  <= acc_busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Control registers, interrupts, pins, read mux
  // ----------------------------------------------------------------
  logic [1:0] dis_q, dis_d;                    // Pin input disable bits
  logic [1:0] flag_q, flag_d;                  // Sticky completion flags
  logic [1:0] ien_q, ien_d;                    // Interrupt enables
  logic [7:0] rdata_d;
  logic [1:0] port_d, clr;
  logic       irq_d;

  // Next values of control state and outputs
  always_comb begin
    dis_d = dis_q;
    ien_d = ien_q;
    clr   = 2'h0;
    if (wr && addr == `CADR_OFF_PIN_DISABLE) begin
      dis_d = wdata[`CADR_PIN_W-1:0];
    end
    if (wr && addr == `CADR_OFF_IRQ_ENABLE) begin
      ien_d = wdata[1:0];
    end
    if (wr && addr == `CADR_OFF_IRQ_CLEAR) begin
      clr = wdata[1:0];                        // Write one clears
    end
    // Set wins over a clear in the same cycle
    flag_d = (flag_q & ~clr) | {acc_ev & !acc_busy_q, inst_ev & !inst_busy_q};
    // Frozen completions flag when they become visible
    flag_d[`CADR_BIT_INST] = flag_d[`CADR_BIT_INST] | (inst_busy_q & rd_inst_hi & (inst_ev | inst_pv_q));
    flag_d[`CADR_BIT_ACC]  = flag_d[`CADR_BIT_ACC]  | (acc_busy_q & rd_acc_hi & (acc_ev | acc_pv_q));
    port_d  = pin_s2_q & ~dis_d;
    irq_d   = |(flag_d & ien_d);
    rdata_d = `CADR_RST_BYTE;
    if (rd) begin
      case (addr)
        `CADR_OFF_PIN_DISABLE: rdata_d = {6'h00, dis_q};  // Reserved read zero
        `CADR_OFF_INST_LOW:    rdata_d = inst_q[7:0];
        `CADR_OFF_INST_HIGH:   rdata_d = inst_q[15:8];
        `CADR_OFF_ACC_B0:      rdata_d = acc_q[7:0];
        `CADR_OFF_ACC_B1:      rdata_d = acc_q[15:8];
        `CADR_OFF_ACC_B2:      rdata_d = acc_q[23:16];
        `CADR_OFF_ACC_B3:      rdata_d = acc_q[31:24];
        `CADR_OFF_SYNC_STATUS: rdata_d = {6'h00, acc_busy_q, inst_busy_q};
        `CADR_OFF_IRQ_STATUS:  rdata_d = {6'h00, flag_q};
        `CADR_OFF_IRQ_ENABLE:  rdata_d = {6'h00, ien_q};
        default:               rdata_d = `CADR_RST_BYTE;  // Unmapped reads zero
      endcase
    end
  end

  // Register control state and outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      dis_q       <= 2'h0;
      flag_q      <= 2'h0;
      ien_q       <= 2'h0;
      rdata       <= `CADR_RST_BYTE;
      pin_buf_off <= 2'h0;
      port_input  <= 2'h0;
      irq         <= 1'b0;
    end else begin
      dis_q       <= dis_d;
      flag_q      <= flag_d;
      ien_q       <= ien_d;
      rdata       <= rdata_d;
      pin_buf_off <= dis_d;
      port_input  <= port_d;
      irq         <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_inst_frozen;
    @(posedge clock) disable iff (rst) inst_busy_q && !rd_inst_hi |=> $stable(inst_q);
  endproperty
  a_inst_frozen: assert property (p_inst_frozen) else $error("instant result changed while frozen");

  property p_inst_busy;
    @(posedge clock) disable iff (rst) rd_inst_lo && !inst_busy_q ##1 !rd_inst_hi |=> inst_busy_q;
  endproperty
  a_inst_busy: assert property (p_inst_busy) else $error("instant busy not held");

  property p_inst_load;
    @(posedge clock) disable iff (rst) inst_ev && !inst_busy_q |=> inst_q == $past(inst_value);
  endproperty
  a_inst_load: assert property (p_inst_load) else $error("instant result not loaded");

  property p_acc_frozen;
    @(posedge clock) disable iff (rst) acc_busy_q && !rd_acc_hi |=> $stable(acc_q);
  endproperty
  a_acc_frozen: assert property (p_acc_frozen) else $error("accumulated result changed while frozen");

  property p_acc_fill;
    @(posedge clock) disable iff (rst) acc_q[13:0] == {14{acc_q[31]}} || acc_q == 32'h0000_0000;
  endproperty
  a_acc_fill: assert property (p_acc_fill) else $error("accumulated low bits not sign filled");

  property p_acc_busy;
    @(posedge clock) disable iff (rst) rd_acc_hi && acc_busy_q |=> !acc_busy_q;
  endproperty
  a_acc_busy: assert property (p_acc_busy) else $error("accumulated busy not released");

  property p_pin_zero;
    @(posedge clock) disable iff (rst) ##1 ((port_input & pin_buf_off) == 2'h0);
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("disabled pin reads nonzero");

  property p_flag_set;
    @(posedge clock) disable iff (rst) inst_ev && !inst_busy_q |=> flag_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("instant flag not set");

  property p_acc_flag;
    @(posedge clock) disable iff (rst) acc_ev && !acc_busy_q |=> flag_q[1] && (irq == (ien_q[1] | (flag_q[0] & ien_q[0])));
  endproperty
  a_acc_flag: assert property (p_acc_flag) else $error("accumulated flag or irq wrong");

  property p_newest;
    @(posedge clock) disable iff (rst) inst_busy_q && rd_inst_hi && inst_ev |=> inst_q == $past(inst_value);
  endproperty
  a_newest: assert property (p_newest) else $error("newest instant result not shown");

  property p_newest_pend;
    @(posedge clock) disable iff (rst) inst_busy_q && rd_inst_hi && !inst_ev && inst_pv_q |=> inst_q == $past(inst_pend_q);
  endproperty
  a_newest_pend: assert property (p_newest_pend) else $error("pending instant result not shown");

endmodule

`default_nettype wire

// [tb/cadr_conv_model.sv]
// Purpose: Converter stand-in that posts conversion results
// Assumes: One fire pulse starts one completion
// Notes:   Value holds while done is high, then turns to garbage
`timescale 1ns/1ps
`default_nettype none

module cadr_conv_model (
  input  wire logic        clock,       // System clock
  input  wire logic        rst,         // Synchronous reset
  input  wire logic        fire_inst,   // Post an instant result
  input  wire logic        fire_acc,    // Post an accumulated result
  input  wire logic [15:0] inst_in,     // Instant value to post
  input  wire logic [17:0] acc_in,      // Accumulated value to post
  output logic             inst_done,   // Instant completion level
  output logic      [15:0] inst_value,  // Instant result
  output logic             acc_done,    // Accumulated completion level
  output logic      [17:0] acc_value    // Accumulated result
);
  logic [2:0]  ci_q;  // Instant done countdown
  logic [2:0]  ca_q;  // Accumulated done countdown
  logic [15:0] vi_q;  // Instant value held
  logic [17:0] va_q;  // Accumulated value held

  // ----------------------------------------
  // Done pulses of six cycles, then value is spoiled
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ci_q <= 3'h0;
      ca_q <= 3'h0;
      vi_q <= 16'h0000;
      va_q <= 18'h0_0000;
    end else begin
      ci_q <= fire_inst ? 3'h6 : (ci_q != 3'h0 ? ci_q - 3'h1 : 3'h0);
      ca_q <= fire_acc ? 3'h6 : (ca_q != 3'h0 ? ca_q - 3'h1 : 3'h0);
      if (fire_inst) begin
        vi_q <= inst_in;
      end
      if (fire_acc) begin
        va_q <= acc_in;
      end
    end
  end

  // Inverse of the held value once the hold has run out
  assign inst_done  = (ci_q != 3'h0);
  assign acc_done   = (ca_q != 3'h0);
  assign inst_value = inst_done ? vi_q : ~vi_q;
  assign acc_value  = acc_done ? va_q : ~va_q;
endmodule

`default_nettype wire

// [tb/cadr_result_readout_tb.sv]
// Purpose: Self-checking bench for the result read-out block
// Assumes: Read data stands one cycle after the read strobe
// Notes:   Converter model posts results, bench acts as the CPU
`include "cadr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cadr_result_readout_tb;
  logic              clock = 1'b0;   // 25 MHz clock
  logic              rst   = 1'b1;   // Reset
  logic              wr    = 1'b0;   // Write strobe
  logic              rd    = 1'b0;   // Read strobe
  logic              fi    = 1'b0;   // Fire instant
  logic              fa    = 1'b0;   // Fire accumulated
  cadr_pkg::cadr_byte_t addr  = 8'h00;  // Offset
  cadr_pkg::cadr_byte_t wdata = 8'h00;  // Write data
  cadr_pkg::cadr_byte_t rdata;          // Read data
  cadr_pkg::cadr_inst_t iv = 16'h0000;  // Instant value to post
  logic [17:0]       av = 18'h0_0000;   // Accumulated value to post
  logic [1:0]        pin_raw = 2'b11;   // Pin levels
  logic              idn, adn, irq;
  logic [15:0]       ival;
  logic [17:0]       aval;
  logic [1:0]        pin_buf_off, port_input;
  int                mismatches = 0;
  int                tests_run  = 0;
  int                cycles     = 0;

  always #20 clock = ~clock;

  cadr_conv_model conv (.clock(clock), .rst(rst), .fire_inst(fi), .fire_acc(fa), .inst_in(iv),
    .acc_in(av), .inst_done(idn), .inst_value(ival), .acc_done(adn), .acc_value(aval));

  cadr_result_readout uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .inst_done(idn), .inst_value(ival), .acc_done(adn), .acc_value(aval),
    .pin_raw(pin_raw), .pin_buf_off(pin_buf_off), .port_input(port_input), .irq(irq));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] v);
    @(posedge clock);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Read data is taken in the cycle after the strobe only
  task automatic rd_chk(string n, logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    rd <= 1'b1; addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(n, {24'h00_0000, e}, {24'h00_0000, rdata});
  endtask

  task automatic conv_i(logic [15:0] v);
    @(posedge clock);
    fi <= 1'b1; iv <= v;
    @(posedge clock);
    fi <= 1'b0;
    repeat (12) @(posedge clock);
  endtask

  task automatic conv_a(logic [17:0] v);
    @(posedge clock);
    fa <= 1'b1; av <= v;
    @(posedge clock);
    fa <= 1'b0;
    repeat (12) @(posedge clock);
  endtask

  // Four accumulated bytes, least significant first
  task automatic rd_acc(logic [17:0] v);
    logic [31:0] e;
    e = {v, {14{v[17]}}};
    for (int i = 0; i < 4; i++) begin
      rd_chk("acc byte", `CADR_OFF_ACC_B0 + 8'(i), e[8*i +: 8]);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset;
    rd_chk("disable reg", `CADR_OFF_PIN_DISABLE, 8'h00);
    rd_chk("inst low", `CADR_OFF_INST_LOW, 8'h00);
    rd_chk("inst high", `CADR_OFF_INST_HIGH, 8'h00);
    rd_acc(18'h0_0000);
    rd_chk("unmapped", 8'h00, 8'h00);
  endtask

  // Low read freezes; a newer result waits until the high read
  task automatic s_inst;
    conv_i(16'h8001);
    rd_chk("inst low", `CADR_OFF_INST_LOW, 8'h01);
    rd_chk("inst busy", `CADR_OFF_SYNC_STATUS, 8'h01);
    conv_i(16'h1234);
    rd_chk("inst high frozen", `CADR_OFF_INST_HIGH, 8'h80);
    rd_chk("inst idle", `CADR_OFF_SYNC_STATUS, 8'h00);
    rd_chk("inst low new", `CADR_OFF_INST_LOW, 8'h34);
    rd_chk("inst high new", `CADR_OFF_INST_HIGH, 8'h12);
  endtask

  task automatic s_acc;
    conv_a(18'h2_0001);
    rd_acc(18'h2_0001);
    conv_a(18'h0_1235);
    rd_acc(18'h0_1235);
    conv_a(18'h0_00aa);
    rd_chk("acc b0", `CADR_OFF_ACC_B0, 8'h00);
    rd_chk("acc busy", `CADR_OFF_SYNC_STATUS, 8'h02);
    conv_a(18'h3_ff00);
    rd_chk("acc b1 frozen", `CADR_OFF_ACC_B1, 8'h80);
    rd_chk("acc b2 frozen", `CADR_OFF_ACC_B2, 8'h2a);
    rd_chk("acc b3 frozen", `CADR_OFF_ACC_B3, 8'h00);
    rd_chk("acc idle", `CADR_OFF_SYNC_STATUS, 8'h00);
    rd_acc(18'h3_ff00);
  endtask

  // Flags set, masked, enabled and cleared by writing one
  task automatic s_irq;
    wr_reg(`CADR_OFF_IRQ_CLEAR, 8'h03);
    wr_reg(`CADR_OFF_IRQ_ENABLE, 8'h01);
    rd_chk("irq enable", `CADR_OFF_IRQ_ENABLE, 8'h01);
    conv_i(16'h0042);
    chk("irq inst", 32'h0000_0001, {31'h0000_0000, irq});
    rd_chk("flags", `CADR_OFF_IRQ_STATUS, 8'h01);
    wr_reg(`CADR_OFF_IRQ_CLEAR, 8'h01);
    rd_chk("flags cleared", `CADR_OFF_IRQ_STATUS, 8'h00);
    chk("irq off", 32'h0000_0000, {31'h0000_0000, irq});
    conv_a(18'h0_0007);
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    rd_chk("acc flag", `CADR_OFF_IRQ_STATUS, 8'h02);
    wr_reg(`CADR_OFF_IRQ_ENABLE, 8'h02);
    repeat (2) @(posedge clock);
    chk("irq acc", 32'h0000_0001, {31'h0000_0000, irq});
    wr_reg(`CADR_OFF_IRQ_CLEAR, 8'h02);
    repeat (2) @(posedge clock);
    chk("irq acc off", 32'h0000_0000, {31'h0000_0000, irq});
  endtask

  // Disabled pins read zero; reserved bits read zero
  task automatic s_pins;
    wr_reg(`CADR_OFF_PIN_DISABLE, 8'hff);
    rd_chk("disable reg", `CADR_OFF_PIN_DISABLE, 8'h03);
    repeat (4) @(posedge clock);
    chk("buf off", 32'h0000_0003, {30'h0000_0000, pin_buf_off});
    chk("port in", 32'h0000_0000, {30'h0000_0000, port_input});
    wr_reg(`CADR_OFF_PIN_DISABLE, 8'h01);
    repeat (4) @(posedge clock);
    chk("buf off one", 32'h0000_0001, {30'h0000_0000, pin_buf_off});
    chk("port in one", 32'h0000_0002, {30'h0000_0000, port_input});
    pin_raw <= 2'b01;
    wr_reg(`CADR_OFF_PIN_DISABLE, 8'h00);
    repeat (4) @(posedge clock);
    chk("buf on", 32'h0000_0000, {30'h0000_0000, pin_buf_off});
    chk("port in open", 32'h0000_0001, {30'h0000_0000, port_input});
  endtask

  // ----------------------------------------
  // Verdict and hang guard
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    s_reset();
    s_inst();
    s_acc();
    s_irq();
    s_pins();
    end_of_test();
  end
endmodule

`default_nettype wire
